// *** bpm_modulator.sv ***
// packet framer, bi-phase modulator and power-path control
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`include "bpm_defines.svh"
// Notes on behaviour
// - power-good open-drain switch is on exactly while supply output is enabled.
// - supply output stays disabled until rectified voltage reaches no-load target.
// - each bit lasts one 0.5 ms bit period, 2 kHz.
// - a one gives two modulation transitions per bit period.
// - a zero gives exactly one transition per bit period.
// - data bytes go out least significant bit first.
// - each byte is an 11-bit character: start, eight data, parity, stop.
// - the start bit is zero.
// - parity makes data plus parity hold an odd count of ones.
// - the stop bit is one.
// - both modulation switches carry the same waveform.
// - current limit is adjusted while packets are being sent.
// - below 300 mA output current the limit is a fixed 400 mA.
// - above 300 mA the limit is measured current plus 50 mA, held at 4095 above 4045 mA.
// - limit is lifted once the packet has finished.
// - synchronous rectification off during startup, diodes rectify.
// - above undervoltage lockout use half-synchronous until load exceeds 120 mA.
// - full synchronous holds until load falls below 100 mA, then half.
// - mode_select_b high with mode_select_a low disables the communication limit.
// - over regulation send error packets every 30 ms, then every 250 ms at target.
module bpm_modulator
    import bpm_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog status inputs
    input  wire logic        rectified_voltage_at_target,
    input  wire logic        rectified_voltage_above_uvlo,
    input  wire logic        input_above_regulation,
    input  wire logic [11:0] measured_output_current,
    input  wire logic        mode_select_a,
    input  wire logic        mode_select_b,
    // pins and analog controls
    output logic             modulation_switch_a,
    output logic             modulation_switch_b,
    output logic             power_good_indicator_oe_n,
    output logic             supply_output_enable,
    output logic [11:0]      current_limit_ma,
    output logic [1:0]       rectifier_mode
);

    bpm_state_t  state;
    bpm_rect_t   rect;
    logic [7:0]  buf_mem [0:`BPM_MAX_BYTES-1];
    logic [4:0]  pkt_len;
    logic [4:0]  byte_idx;
    logic [10:0] shreg;
    logic [3:0]  bit_cnt;
    logic [14:0] half_cnt;
    logic        second_half;
    logic        mod_level;
    logic        send_req;
    logic        err_en;
    logic        sync_ok;
    logic        active;
    logic        ever_at_target;
    logic [27:0] err_cnt;
    logic        err_fire;
    logic        setup_done;
    logic        apb_write;
    logic        apb_read;
    logic        addr_ok;
    logic        in_buf;
    logic [4:0]  buf_sel;
    logic        half_tick;
    logic [7:0]  cur_byte;

    assign apb_write = psel & penable & pwrite;
    assign apb_read  = psel & ~penable & ~pwrite;
    assign in_buf    = (paddr >= `BPM_ADDR_BUF) && (paddr <= `BPM_ADDR_BUF_END)
                       && (paddr[1:0] == 2'b00);
    assign buf_sel   = 5'(paddr[6:2]);
    assign addr_ok   = in_buf || paddr == `BPM_ADDR_CTRL || paddr == `BPM_ADDR_STATUS
                       || paddr == `BPM_ADDR_LEN || paddr == `BPM_ADDR_ILIM;
    assign half_tick = (half_cnt == 15'(`BPM_HALF_CYC - 1));
    assign cur_byte  = buf_mem[byte_idx];

    // apb: zero wait states; ready asserted in every access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (apb_read) begin
            if (paddr == `BPM_ADDR_CTRL) begin
                prdata <= {29'h0, sync_ok, err_en, send_req};
            end else if (paddr == `BPM_ADDR_STATUS) begin
                prdata <= {24'h0, 2'(rect), supply_output_enable, active,
                           4'(state)};
            end else if (paddr == `BPM_ADDR_LEN) begin
                prdata <= {27'h0, pkt_len};
            end else if (paddr == `BPM_ADDR_ILIM) begin
                prdata <= {20'h0, current_limit_ma};
            end else if (in_buf) begin
                prdata <= {24'h0, buf_mem[buf_sel]};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // buffer writes are refused while a packet is on the wire
    always_ff @(posedge pclk) begin
        if (apb_write && in_buf && !active) begin
            buf_mem[buf_sel] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pkt_len <= 5'h0;
            err_en  <= 1'b0;
            sync_ok <= 1'b0;
        end else if (apb_write && !active) begin
            if (paddr == `BPM_ADDR_LEN) begin
                pkt_len <= (pwdata[4:0] > `BPM_MAX_BYTES) ? `BPM_MAX_BYTES : pwdata[4:0];
            end else if (paddr == `BPM_ADDR_CTRL) begin
                err_en  <= pwdata[`BPM_CTRL_ERR_EN];
                sync_ok <= pwdata[`BPM_CTRL_SYNC_OK];
            end
        end
    end

    // send request: set by software or the error timer, cleared at packet start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            send_req <= 1'b0;
        end else if (apb_write && paddr == `BPM_ADDR_CTRL && pwdata[`BPM_CTRL_SEND]) begin
            send_req <= 1'b1;
        end else if (err_fire && err_en) begin
            send_req <= 1'b1;
        end else if (state == BPM_LOAD && byte_idx == 5'h0) begin
            send_req <= 1'b0;
        end
    end

    // error packet period: short while below target, long while at target
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_cnt  <= 28'h0;
            err_fire <= 1'b0;
        end else if (!input_above_regulation) begin
            err_cnt  <= 28'h0;
            err_fire <= 1'b0;
        end else if ((!rectified_voltage_at_target
                      && err_cnt >= 28'(`BPM_ERR_FAST_CYC - 1))
                     || err_cnt >= 28'(`BPM_ERR_SLOW_CYC - 1)) begin
            err_cnt  <= 28'h0;
            err_fire <= 1'b1;
        end else begin
            err_cnt  <= err_cnt + 28'h1;
            err_fire <= 1'b0;
        end
    end

    // half-bit timebase, restarted with each packet so bits align
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt    <= 15'h0;
            second_half <= 1'b0;
        end else if (state != BPM_SHIFT) begin
            half_cnt    <= 15'h0;
            second_half <= 1'b0;
        end else if (half_tick) begin
            half_cnt    <= 15'h0;
            second_half <= ~second_half;
        end else begin
            half_cnt <= half_cnt + 15'h1;
        end
    end

    // framer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= BPM_IDLE;
            byte_idx <= 5'h0;
            shreg    <= 11'h0;
            bit_cnt  <= 4'h0;
            active   <= 1'b0;
        end else begin
            case (state)
                BPM_IDLE: begin
                    byte_idx <= 5'h0;
                    if (send_req && pkt_len != 5'h0) begin
                        state  <= BPM_LOAD;
                        active <= 1'b1;
                    end
                end
                BPM_LOAD: begin
                    // shifted out from bit 0: start, data lsb first, parity, stop
                    shreg   <= {1'b1, ~^cur_byte, cur_byte, 1'b0};
                    bit_cnt <= 4'h0;
                    state   <= BPM_SHIFT;
                end
                BPM_SHIFT: begin
                    if (half_tick && second_half) begin
                        shreg   <= {1'b0, shreg[10:1]};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == `BPM_CHAR_BITS - 4'h1) begin
                            if (byte_idx == pkt_len - 5'h1) begin
                                state <= BPM_DONE;
                            end else begin
                                // next character loaded in the same cycle: no gap
                                byte_idx <= byte_idx + 5'h1;
                                shreg    <= {1'b1, ~^buf_mem[byte_idx + 5'h1],
                                             buf_mem[byte_idx + 5'h1], 1'b0};
                                bit_cnt  <= 4'h0;
                            end
                        end
                    end
                end
                BPM_DONE: begin
                    active <= 1'b0;
                    state  <= BPM_IDLE;
                end
                default: begin
                    state <= BPM_IDLE;
                end
            endcase
        end
    end

    // differential bi-phase: toggle at every boundary except the packet's end, mid-bit extra for ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_level <= 1'b0;
        end else if (state == BPM_LOAD) begin
            mod_level <= ~mod_level;
        end else if (state == BPM_SHIFT && half_tick) begin
            if (second_half && state == BPM_SHIFT && !(bit_cnt == `BPM_CHAR_BITS - 4'h1
                && byte_idx == pkt_len - 5'h1)) begin
                mod_level <= ~mod_level;
            end else if (!second_half && shreg[0]) begin
                mod_level <= ~mod_level;
            end
        end
    end

    // both switches track one waveform so parallel resistors share the load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modulation_switch_a <= 1'b0;
            modulation_switch_b <= 1'b0;
        end else begin
            modulation_switch_a <= mod_level;
            modulation_switch_b <= mod_level;
        end
    end

    // supply output on after first convergence at no load, while above uvlo and mode selects not both high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ever_at_target       <= 1'b0;
            supply_output_enable <= 1'b0;
        end else begin
            if (rectified_voltage_at_target) begin
                ever_at_target <= 1'b1;
            end
            supply_output_enable <= ever_at_target && rectified_voltage_above_uvlo
                                    && !(mode_select_a && mode_select_b);
        end
    end

    // open drain: enable low pulls the pin down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_good_indicator_oe_n <= 1'b1;
        end else begin
            power_good_indicator_oe_n <= ~(ever_at_target && rectified_voltage_above_uvlo
                                           && !(mode_select_a && mode_select_b));
        end
    end

    // communication current limit, lifted outside packets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_limit_ma <= `BPM_ILIM_NONE_MA;
        end else if (!active || (mode_select_b && !mode_select_a)) begin
            current_limit_ma <= `BPM_ILIM_NONE_MA;
        end else if (measured_output_current > `BPM_ILIM_TRACK_MA) begin
            // saturate so the sum cannot wrap below the load
            current_limit_ma <= (measured_output_current > (`BPM_ILIM_NONE_MA - `BPM_ILIM_MARGIN_MA))
                                ? `BPM_ILIM_NONE_MA
                                : measured_output_current + `BPM_ILIM_MARGIN_MA;
        end else begin
            current_limit_ma <= `BPM_ILIM_FIXED_MA;
        end
    end

    // startup gate: synchronous modes only after software marks startup done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_done <= 1'b0;
        end else begin
            setup_done <= sync_ok;
        end
    end

    // rectifier mode with 120/100 mA hysteresis
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rect <= BPM_RECT_DIODE;
        end else if (!rectified_voltage_above_uvlo || !setup_done) begin
            rect <= BPM_RECT_DIODE;
        end else begin
            case (rect)
                BPM_RECT_DIODE: begin
                    rect <= BPM_RECT_HALF;
                end
                BPM_RECT_HALF: begin
                    if (measured_output_current > `BPM_SYNC_UP_MA) begin
                        rect <= BPM_RECT_FULL;
                    end
                end
                BPM_RECT_FULL: begin
                    if (measured_output_current < `BPM_SYNC_DOWN_MA) begin
                        rect <= BPM_RECT_HALF;
                    end
                end
                default: begin
                    rect <= BPM_RECT_DIODE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rectifier_mode <= 2'b00;
        end else begin
            rectifier_mode <= 2'(rect);
        end
    end

endmodule

// *** bpm_defines.svh ***
// constants for the backscatter packet modulator
`ifndef BPM_DEFINES_SVH
`define BPM_DEFINES_SVH

`define BPM_CLK_HZ          125000000
`define BPM_BIT_PERIOD_US   500
`define BPM_HALF_CYC        31250
`define BPM_ERR_FAST_MS     30
`define BPM_ERR_SLOW_MS     250
`define BPM_CYC_PER_MS      125000
`define BPM_ERR_FAST_CYC    (`BPM_ERR_FAST_MS * `BPM_CYC_PER_MS)
`define BPM_ERR_SLOW_CYC    (`BPM_ERR_SLOW_MS * `BPM_CYC_PER_MS)

`define BPM_CHAR_BITS       4'd11
`define BPM_MAX_BYTES       5'd28

`define BPM_ILIM_TRACK_MA   12'd300
`define BPM_ILIM_FIXED_MA   12'd400
`define BPM_ILIM_MARGIN_MA  12'd50
`define BPM_ILIM_NONE_MA    12'hfff
`define BPM_SYNC_UP_MA      12'd120
`define BPM_SYNC_DOWN_MA    12'd100

`define BPM_ADDR_CTRL       12'h000
`define BPM_ADDR_STATUS     12'h004
`define BPM_ADDR_LEN        12'h008
`define BPM_ADDR_ILIM       12'h00c
`define BPM_ADDR_BUF        12'h100
`define BPM_ADDR_BUF_END    12'h16c

`define BPM_CTRL_SEND       0
`define BPM_CTRL_ERR_EN     1
`define BPM_CTRL_SYNC_OK    2

`endif

// *** bpm_pkg.sv ***
// types for the backscatter packet modulator
package bpm_pkg;
    typedef enum logic [3:0] {
        BPM_IDLE  = 4'b0001,
        BPM_LOAD  = 4'b0010,
        BPM_SHIFT = 4'b0100,
        BPM_DONE  = 4'b1000
    } bpm_state_t;

    typedef enum logic [1:0] {
        BPM_RECT_DIODE = 2'b00,
        BPM_RECT_HALF  = 2'b01,
        BPM_RECT_FULL  = 2'b10
    } bpm_rect_t;
endpackage

// *** bpm_modulator_chk_sva.sv ***
// port assertions for the backscatter packet modulator
module bpm_modulator_chk
    import bpm_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // status inputs
    input wire logic        rectified_voltage_at_target,
    input wire logic [11:0] measured_output_current,
    input wire logic        mode_select_a,
    input wire logic        mode_select_b,
    // watched outputs
    input wire logic        modulation_switch_a,
    input wire logic        modulation_switch_b,
    input wire logic        power_good_indicator_oe_n,
    input wire logic        supply_output_enable,
    input wire logic [11:0] current_limit_ma,
    input wire logic [1:0]  rectifier_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // gap saturates so a long idle never looks like a bit period
    logic        sw_q;
    logic        seen;
    logic        reached;
    logic [16:0] gap;
    // reached: target seen in an earlier cycle; the supply may stay latched after that
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_q    <= 1'b0;
            seen    <= 1'b0;
            reached <= 1'b0;
            gap     <= '0;
        end else begin
            sw_q    <= modulation_switch_a;
            reached <= reached | rectified_voltage_at_target;
            seen <= seen | (modulation_switch_a != sw_q);
            gap  <= (modulation_switch_a != sw_q) ? '0 : (&gap ? gap : gap + 17'd1);
        end
    end
    property p_pg; supply_output_enable == !power_good_indicator_oe_n; endproperty
    a_pg: assert property (p_pg) else $error("indicator differs from supply");
    property p_sup;
        !reached |-> !supply_output_enable;
    endproperty
    a_sup: assert property (p_sup) else $error("supply on before target");
    property p_sw; modulation_switch_a == modulation_switch_b; endproperty
    a_sw: assert property (p_sw) else $error("switches differ");
    property p_bit;
        modulation_switch_a != sw_q && seen && gap < 17'd62500 |-> gap == 17'd31249 || gap == 17'd62499;
    endproperty
    a_bit: assert property (p_bit) else $error("toggle off the half-bit grid");
    property p_fix;
        current_limit_ma != 12'hfff && $past(measured_output_current) <= 12'd300
            |-> current_limit_ma == 12'd400;
    endproperty
    a_fix: assert property (p_fix) else $error("fixed limit wrong");
    property p_trk;
        current_limit_ma != 12'hfff && $past(measured_output_current) > 12'd300
            |-> current_limit_ma == $past(measured_output_current) + 12'd50;
    endproperty
    a_trk: assert property (p_trk) else $error("tracking limit wrong");
    property p_off; $past(mode_select_b) && !$past(mode_select_a) |-> current_limit_ma == 12'hfff;
    endproperty
    a_off: assert property (p_off) else $error("limit not disabled");
    property p_full;
        $rose(rectifier_mode == BPM_RECT_FULL) |-> $past(measured_output_current, 2) > 12'd120;
    endproperty
    a_full: assert property (p_full) else $error("full sync too early");
    property p_half;
        $fell(rectifier_mode == BPM_RECT_FULL) && rectifier_mode == BPM_RECT_HALF
            |-> $past(measured_output_current, 2) < 12'd100;
    endproperty
    a_half: assert property (p_half) else $error("full sync left too early");
    c_tog: cover property (modulation_switch_a != sw_q && seen);
    c_full: cover property (rectifier_mode == BPM_RECT_FULL);
    c_trk: cover property (current_limit_ma > 12'd400 && current_limit_ma != 12'hfff);
endmodule

bind bpm_modulator bpm_modulator_chk bpm_modulator_chk_i (
    .pclk, .presetn, .rectified_voltage_at_target, .measured_output_current, .mode_select_a,
    .mode_select_b, .modulation_switch_a, .modulation_switch_b, .power_good_indicator_oe_n,
    .supply_output_enable, .current_limit_ma, .rectifier_mode
);

// *** bpm_demod_model.sv ***
// transmitter-side demodulator model: decodes bi-phase bits from the coil load
module bpm_demod_model (
    // clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // coil load seen by the transmitter
    input wire logic         coil_load,
    // decoded character, newest bit at the top
    output logic [3:0]       bit_count,
    output logic [10:0]      char_bits,
    output logic             mid_seen,
    output logic             framing_err
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 31250;
    logic        prev;
    logic        busy;
    logic [16:0] gap;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev        <= 1'b0;
            busy        <= 1'b0;
            gap         <= '0;
            bit_count   <= '0;
            char_bits   <= '0;
            mid_seen    <= 1'b0;
            framing_err <= 1'b0;
        end else begin
            prev <= coil_load;
            gap  <= (coil_load != prev) ? '0 : (&gap ? gap : gap + 17'd1);
            if (coil_load != prev) begin
                if (!busy) begin
                    busy <= 1'b1;
                end else if (gap == 17'(HALF - 1) && !mid_seen) begin
                    mid_seen <= 1'b1;
                end else if (mid_seen ? gap == 17'(HALF - 1) : gap == 17'(2 * HALF - 1)) begin
                    char_bits <= {mid_seen, char_bits[10:1]};
                    bit_count <= bit_count + 4'd1;
                    mid_seen  <= 1'b0;
                end else begin
                    framing_err <= 1'b1;
                end
            end
        end
    end
endmodule

// *** backscatter_packet_modulator_tb.sv ***
// self-checking bench for the backscatter packet modulator
`include "bpm_defines.svh"
module backscatter_packet_modulator_tb
    import bpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        rectified_voltage_at_target, rectified_voltage_above_uvlo, input_above_regulation;
    logic        mode_select_a, mode_select_b, modulation_switch_a, modulation_switch_b;
    logic        power_good_indicator_oe_n, supply_output_enable, mid_seen, framing_err;
    logic [1:0]  rectifier_mode;
    logic [3:0]  bit_count;
    logic [10:0] char_bits;
    logic [11:0] paddr, measured_output_current, current_limit_ma, c;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [7:0]  byte_v;
    int          mismatches, num_checks, n;
    logic [11:0] cur_tab [5] = '{12'd50, 12'd120, 12'd121, 12'd100, 12'd99};
    bpm_rect_t   mode_tab [5] = '{BPM_RECT_HALF, BPM_RECT_HALF, BPM_RECT_FULL, BPM_RECT_FULL,
                                  BPM_RECT_HALF};

    bpm_modulator bpm_modulator_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .rectified_voltage_at_target, .rectified_voltage_above_uvlo, .input_above_regulation,
        .measured_output_current, .mode_select_a, .mode_select_b, .modulation_switch_a,
        .modulation_switch_b, .power_good_indicator_oe_n, .supply_output_enable,
        .current_limit_ma, .rectifier_mode
    );
    bpm_demod_model bpm_demod_model_i (
        .pclk, .presetn, .coil_load(modulation_switch_a), .bit_count, .char_bits, .mid_seen,
        .framing_err
    );

    always #4 pclk = ~pclk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [11:0] exp_limit(input logic [11:0] cur, input logic b);
        if (b) return 12'hfff;
        return (cur > 12'd300) ? cur + 12'd50 : 12'd400;
    endfunction

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s read %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [11:0] got, input logic [11:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s is %h want %h", $time, what, got, exp);
        end
    endtask
    // entered just after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        chk_pin(pready, 1, "pready");
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        // three half-bits of link traffic plus setup margin
        repeat (3 * `BPM_HALF_CYC + 4000) @(posedge pclk);
        mismatches++;
        close_out;
    end

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        rectified_voltage_at_target = 0; rectified_voltage_above_uvlo = 0;
        input_above_regulation = 0; measured_output_current = 0;
        mode_select_a = 0; mode_select_b = 0; seed = 32'h7136;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_pin(power_good_indicator_oe_n, 1, "indicator");
        chk_pin(current_limit_ma, 12'hfff, "idle limit");
        apb(1'b0, 12'h020, 32'h0);
        chk_reg(rd, 32'h0, "unmapped");
        chk_pin(err, 1, "unmapped error");
        apb(1'b1, `BPM_ADDR_LEN, 32'h1);
        apb(1'b0, `BPM_ADDR_LEN, 32'h0);
        chk_reg(rd, 32'h1, "length");
        $display("test registers done");
        rectified_voltage_above_uvlo <= 1'b1;
        measured_output_current <= 12'd150;
        repeat (4) @(posedge pclk);
        chk_pin(rectifier_mode, BPM_RECT_DIODE, "startup rect");
        apb(1'b1, `BPM_ADDR_CTRL, 32'h4);
        for (int i = 0; i < 5; i++) begin
            measured_output_current <= cur_tab[i];
            repeat (4) @(posedge pclk);
            chk_pin(rectifier_mode, mode_tab[i], "rect mode");
        end
        $display("test rectifier done");
        chk_pin(supply_output_enable, 0, "supply early");
        rectified_voltage_at_target <= 1'b1;
        repeat (3) @(posedge pclk);
        chk_pin(power_good_indicator_oe_n, 0, "indicator on");
        apb(1'b0, `BPM_ADDR_STATUS, 32'h0);
        chk_reg(rd & 32'h20, 32'h20, "status supply");
        $display("test supply done");
        byte_v = (rnd() | 8'h01) & 8'h7f;
        measured_output_current <= 12'd200;
        apb(1'b1, `BPM_ADDR_BUF, {24'h0, byte_v});
        apb(1'b1, `BPM_ADDR_CTRL, 32'h5);
        n = 0;
        while (modulation_switch_a !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        chk_pin(modulation_switch_a, 1, "first edge");
        for (int i = 0; i < 8; i++) begin
            c = (i == 0) ? 12'd300 : (i[0] ? 12'd301 + 12'(rnd() % 700) : 12'(rnd() % 300));
            measured_output_current <= c;
            mode_select_b <= (i == 7);
            repeat (3) @(posedge pclk);
            chk_pin(current_limit_ma, exp_limit(c, i == 7), "limit");
        end
        mode_select_b <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b0, `BPM_ADDR_ILIM, 32'h0);
        chk_reg(rd, {20'h0, exp_limit(c, 1'b0)}, "limit reg");
        $display("test limit done");
        n = 0;
        while (bit_count !== 4'd1 && n < 70000) begin
            @(posedge pclk);
            n++;
        end
        chk_pin(bit_count, 1, "bits seen");
        chk_pin(char_bits[10], 0, "start bit");
        n = 0;
        while (mid_seen !== 1'b1 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        chk_pin(mid_seen, byte_v[0], "first data bit");
        chk_pin(framing_err, 0, "framing");
        chk_pin(modulation_switch_b, modulation_switch_a, "switch pair");
        $display("test link done");
        close_out;
    end
endmodule
